// ---- include/occs_pkg.sv ----
// package: register map, field positions and codes for output clock control/status
package occs_pkg;

  localparam int NUM_OUT = 3;

  // register offsets (byte-wide register space)
  localparam logic [7:0] ADDR_STATUS_1   = 8'h53;
  localparam logic [7:0] ADDR_STATUS_2   = 8'h54;
  localparam logic [7:0] ADDR_STATUS_3   = 8'h55;
  localparam logic [7:0] ADDR_IRQ_SUM    = 8'h45;
  localparam logic [7:0] ADDR_PHASE_STAT = 8'h46;
  localparam logic [7:0] ADDR_MUX_SEL    = 8'h30;
  localparam logic [7:0] ADDR_DIV_CFG_1  = 8'h60;
  localparam logic [7:0] ADDR_DRV_CFG_1  = 8'h61;
  localparam logic [7:0] ADDR_SRC_CFG_1  = 8'h62;
  localparam logic [7:0] ADDR_CFG_STRIDE = 8'h10;

  // status register bits
  localparam int SR_SLOW_IE  = 7;
  localparam int SR_SLOW_L   = 6;
  localparam int SR_SLOW_LVL = 5;
  localparam int SR_RES_IE   = 4;
  localparam int SR_RES_L    = 3;
  localparam int SR_HALT_IE  = 2;
  localparam int SR_HALT_L   = 1;
  localparam int SR_HALT_LV  = 0;

  // phase status bits
  localparam int PS_BUSY  = 1;
  localparam int PS_ARMED = 0;

  // mux select fields
  localparam int MX_PIN_SW = 6;
  localparam int MX_ALT_LO = 3;
  localparam int MX_PRI_LO = 0;

  // divider config
  localparam int DC_PHASE_EN = 7;

  // driver config fields
  localparam int DR_INV     = 6;
  localparam int DR_DRV_LO  = 4;
  localparam int DR_HIZ_HLT = 3;
  localparam int DR_FMT_LO  = 0;

  // source config bits
  localparam int SC_SLOW_EN = 7;
  localparam int SC_NEG_LS  = 5;
  localparam int SC_SRC_SEL = 4;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;

  // divider frequency ceiling, MHz
  localparam int MED_DIV_MAX_MHZ = 425;

  // input source codes
  typedef enum logic [2:0] {
    SRC_OSC = 3'h0,
    SRC_IN_A = 3'h1,
    SRC_IN_B = 3'h2,
    SRC_IN_C = 3'h3
  } occs_src_t;

  // output format codes
  typedef enum logic [2:0] {
    FMT_OFF     = 3'h0,
    FMT_CML_STD = 3'h1,
    FMT_CML_NAR = 3'h2,
    FMT_HSTL    = 3'h3,
    FMT_CMOS_IP = 3'h4,
    FMT_NEG_ONE = 3'h5,
    FMT_POS_ONE = 3'h6,
    FMT_CMOS_CP = 3'h7
  } occs_fmt_t;

endpackage

// ---- include/occs_path_if.sv ----
// interface: per-output configuration and live path signals
`timescale 1ns/1ps
interface occs_path_if;
  logic [7:0] div_cfg;
  logic [7:0] drv_cfg;
  logic [7:0] src_cfg;
  logic       clk_hs;
  logic       clk_ms;
  logic       clk_ls;
  logic       halted;
  logic       pos_o;
  logic       pos_oe;
  logic       neg_o;
  logic       neg_oe;
  logic [3:0] drv_sect;
  logic       phase_part;
  modport ctrl (output div_cfg, drv_cfg, src_cfg, clk_hs, clk_ms, clk_ls, halted,
                input pos_o, pos_oe, neg_o, neg_oe, drv_sect, phase_part);
  modport path (input div_cfg, drv_cfg, src_cfg, clk_hs, clk_ms, clk_ls, halted,
                output pos_o, pos_oe, neg_o, neg_oe, drv_sect, phase_part);
endinterface

// ---- hw/occs_out_path.sv ----
// output path: source select, polarity, format, enable and drive decode
`timescale 1ns/1ps
module occs_out_path (
  // configuration and clocks
  occs_path_if.path  pif,
  // global per-output enable
  input  wire logic  i_out_en
);

  logic       med_zero;
  logic       path_clk;
  logic       pclk;
  logic       neg_clk;
  logic       hiz_stop;
  logic [2:0] fmt;

  // zero divider bypasses source select, slow routing, halt hi-z and phase participation; inversion still applies
  assign med_zero = (pif.div_cfg[6:0] == 7'h00);
  // source select only valid when divider is nonzero
  assign path_clk = med_zero ? pif.clk_hs :
                    (pif.src_cfg[occs_pkg::SC_SRC_SEL] ? pif.clk_ls : pif.clk_ms);
  assign pclk     = path_clk ^ pif.drv_cfg[occs_pkg::DR_INV];
  // slow route to negative pin is never inverted
  assign neg_clk  = (pif.src_cfg[occs_pkg::SC_NEG_LS] && !med_zero) ? pif.clk_ls
                    : pclk;
  assign hiz_stop = pif.drv_cfg[occs_pkg::DR_HIZ_HLT] && pif.halted && !med_zero;
  assign fmt      = pif.drv_cfg[2:0];
  assign pif.phase_part = pif.div_cfg[occs_pkg::DC_PHASE_EN] && !med_zero;

  // drive sections: field value plus one sections on
  always_comb begin
    case (pif.drv_cfg[5:4])
      2'b00:   pif.drv_sect = 4'h1;
      2'b01:   pif.drv_sect = 4'h3;
      2'b10:   pif.drv_sect = 4'h7;
      default: pif.drv_sect = 4'hF;
    endcase
  end

  // format decode to pin drive
  always_comb begin
    pif.pos_o  = pclk;
    pif.neg_o  = ~pclk;
    pif.pos_oe = 1'b1;
    pif.neg_oe = 1'b1;
    case (fmt)
      occs_pkg::FMT_OFF: begin
        pif.pos_oe = 1'b0;
        pif.neg_oe = 1'b0;
      end
      occs_pkg::FMT_CMOS_IP: begin
        pif.neg_o = neg_clk;
      end
      occs_pkg::FMT_NEG_ONE: begin
        pif.pos_oe = 1'b0;
        pif.neg_o  = neg_clk;
      end
      occs_pkg::FMT_POS_ONE: begin
        pif.neg_oe = 1'b0;
      end
      occs_pkg::FMT_CMOS_CP: begin
        pif.neg_o = pif.src_cfg[occs_pkg::SC_NEG_LS] ? neg_clk : ~pclk;
      end
      default: begin
      end
    endcase
    // disabled output, or halted with hiz and a nonzero divider, wins over format
    if (!i_out_en || hiz_stop) begin
      pif.pos_oe = 1'b0;
      pif.neg_oe = 1'b0;
    end
  end

endmodule

// ---- hw/occs_top.sv ----
// top: output clock path control and status registers for three outputs
`timescale 1ns/1ps
module occs_top (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // selected input source clock and selector pin
  input  wire logic        i_path_clk,
  input  wire logic        i_switch_pin,
  output logic      [2:0]  o_mux_sel,
  // phase adjust engine status
  input  wire logic        i_phase_armed,
  input  wire logic        i_phase_busy,
  output logic      [2:0]  o_phase_part,
  // per-output slow divider clock, halt state and output enable
  input  wire logic [2:0]  i_slow_clk,
  input  wire logic [2:0]  i_halted,
  input  wire logic [2:0]  i_out_en,
  // output pins
  output logic      [2:0]  o_pos_pin,
  output logic      [2:0]  o_pos_pin_oe,
  output logic      [2:0]  o_neg_pin,
  output logic      [2:0]  o_neg_pin_oe,
  output logic      [11:0] o_drive_sect,
  output logic      [2:0]  o_irq_sum
);

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // release reset through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [11:0] sync_a;
  logic [11:0] sync_b;
  logic [2:0]  slow_s;
  logic [2:0]  halt_s;
  logic        arm_s;
  logic        busy_s;
  logic        pin_s;

  // two flops on every asynchronous status input
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 12'h000;
      sync_b <= 12'h000;
    end else begin
      sync_a <= {i_slow_clk, i_halted, i_phase_armed, i_phase_busy, i_switch_pin, 3'h0};
      sync_b <= sync_a;
    end
  end

  assign slow_s = sync_b[11:9];
  assign halt_s = sync_b[8:6];
  assign arm_s  = sync_b[5];
  assign busy_s = sync_b[4];
  assign pin_s  = sync_b[3];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] mux_cfg;
  logic [7:0] div_cfg [3];
  logic [7:0] drv_cfg [3];
  logic [7:0] src_cfg [3];
  logic [2:0] ien_slow;
  logic [2:0] ien_res;
  logic [2:0] ien_halt;

  // address decode helper: which output's config block
  function automatic logic cfg_hit(input logic [7:0] addr, input logic [7:0] base,
                                   input int idx);
    cfg_hit = (addr == 8'(base + 8'(idx) * occs_pkg::ADDR_CFG_STRIDE));
  endfunction

  // mux select register
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_cfg <= occs_pkg::RST_ZERO;
    end else if (i_reg_wr && i_reg_addr == occs_pkg::ADDR_MUX_SEL) begin
      mux_cfg <= i_reg_wdata;
    end
  end

  // effective input mux selection
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mux_sel <= 3'h0;
    end else if (mux_cfg[occs_pkg::MX_PIN_SW] && pin_s) begin
      o_mux_sel <= mux_cfg[occs_pkg::MX_ALT_LO +: 3];
    end else begin
      o_mux_sel <= mux_cfg[occs_pkg::MX_PRI_LO +: 3];
    end
  end

  // ---------------------------------------------------------------
  // per-output config, status and paths
  // ---------------------------------------------------------------
  logic [2:0] slow_lat;
  logic [2:0] res_lat;
  logic [2:0] halt_lat;
  logic [2:0] slow_prev;
  logic [2:0] halt_prev;
  logic [2:0] slow_lvl;
  logic [2:0] slow_en;
  logic [2:0] sr_wr;
  logic [7:0] sr_val [3];

  genvar g;
  generate
    for (g = 0; g < occs_pkg::NUM_OUT; g++) begin : g_out
      occs_path_if pif ();

      // config registers for this output
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          div_cfg[g] <= occs_pkg::RST_ZERO;
          drv_cfg[g] <= occs_pkg::RST_ZERO;
          src_cfg[g] <= occs_pkg::RST_ZERO;
        end else if (i_reg_wr) begin
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_DIV_CFG_1, g)) begin
            div_cfg[g] <= i_reg_wdata;
          end
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_DRV_CFG_1, g)) begin
            drv_cfg[g] <= i_reg_wdata;
          end
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_SRC_CFG_1, g)) begin
            src_cfg[g] <= i_reg_wdata;
          end
        end
      end

      assign sr_wr[g]   = i_reg_wr &&
                          (i_reg_addr == 8'(occs_pkg::ADDR_STATUS_1 + 8'(g)));
      assign slow_en[g] = src_cfg[g][occs_pkg::SC_SLOW_EN];
      // level bit: 1 when slow clock low, forced low when disabled
      assign slow_lvl[g] = slow_en[g] & ~slow_s[g];

      // interrupt enables
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ien_slow[g] <= 1'b0;
          ien_res[g]  <= 1'b0;
          ien_halt[g] <= 1'b0;
        end else if (sr_wr[g]) begin
          ien_slow[g] <= i_reg_wdata[occs_pkg::SR_SLOW_IE];
          ien_res[g]  <= i_reg_wdata[occs_pkg::SR_RES_IE];
          ien_halt[g] <= i_reg_wdata[occs_pkg::SR_HALT_IE];
        end
      end

      // edge history; halt tracks synced live state from reset
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          slow_prev[g] <= 1'b0;
          halt_prev[g] <= 1'b0;
        end else begin
          slow_prev[g] <= slow_s[g];
          halt_prev[g] <= halt_s[g];
        end
      end

      // latched flags: set wins over write-one clear
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          slow_lat[g] <= 1'b0;
          res_lat[g]  <= 1'b0;
          halt_lat[g] <= 1'b0;
        end else begin
          if (!slow_en[g]) begin
            slow_lat[g] <= 1'b0;
          end else if (slow_s[g] && !slow_prev[g]) begin
            slow_lat[g] <= 1'b1;
          end else if (sr_wr[g] && i_reg_wdata[occs_pkg::SR_SLOW_L]) begin
            slow_lat[g] <= 1'b0;
          end
          if (!halt_s[g] && halt_prev[g]) begin
            res_lat[g] <= 1'b1;
          end else if (sr_wr[g] && i_reg_wdata[occs_pkg::SR_RES_L]) begin
            res_lat[g] <= 1'b0;
          end
          if (halt_s[g] && !halt_prev[g]) begin
            halt_lat[g] <= 1'b1;
          end else if (sr_wr[g] && i_reg_wdata[occs_pkg::SR_HALT_L]) begin
            halt_lat[g] <= 1'b0;
          end
        end
      end

      assign sr_val[g] = {ien_slow[g], slow_lat[g], slow_lvl[g], ien_res[g], res_lat[g],
                          ien_halt[g], halt_lat[g], halt_s[g]};

      // summary: any latched flag with its enable
      assign o_irq_sum[g] = (ien_slow[g] & slow_lat[g]) | (ien_res[g] & res_lat[g]) |
                            (ien_halt[g] & halt_lat[g]);

      // connect path
      assign pif.div_cfg = div_cfg[g];
      assign pif.drv_cfg = drv_cfg[g];
      assign pif.src_cfg = src_cfg[g];
      assign pif.clk_hs  = i_path_clk;
      assign pif.clk_ms  = i_path_clk;
      assign pif.clk_ls  = i_slow_clk[g];
      // synced copy: the halt level comes from the output clock domain
      assign pif.halted  = halt_s[g];

      occs_out_path u_path (
        .pif      (pif.path),
        .i_out_en (i_out_en[g])
      );

      assign o_pos_pin[g]          = pif.pos_o;
      assign o_pos_pin_oe[g]       = pif.pos_oe;
      assign o_neg_pin[g]          = pif.neg_o;
      assign o_neg_pin_oe[g]       = pif.neg_oe;
      assign o_drive_sect[4*g +: 4] = pif.drv_sect;
      assign o_phase_part[g]       = pif.phase_part;
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;

  // registered read data
  always_comb begin
    next_rdata = 8'h00;
    case (i_reg_addr)
      occs_pkg::ADDR_STATUS_1:   next_rdata = sr_val[0];
      occs_pkg::ADDR_STATUS_2:   next_rdata = sr_val[1];
      occs_pkg::ADDR_STATUS_3:   next_rdata = sr_val[2];
      occs_pkg::ADDR_IRQ_SUM:    next_rdata = {5'h00, o_irq_sum};
      occs_pkg::ADDR_PHASE_STAT: next_rdata = {6'h00, busy_s, arm_s};
      occs_pkg::ADDR_MUX_SEL:    next_rdata = mux_cfg;
      default: begin
        for (int k = 0; k < occs_pkg::NUM_OUT; k++) begin
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_DIV_CFG_1, k)) next_rdata = div_cfg[k];
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_DRV_CFG_1, k)) next_rdata = drv_cfg[k];
          if (cfg_hit(i_reg_addr, occs_pkg::ADDR_SRC_CFG_1, k)) next_rdata = src_cfg[k];
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

endmodule

// ---- sim/occs_top_assertions.sv ----
// checker: port-level properties of the output clock control block
`timescale 1ns/1ps
module occs_top_assertions (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  // register port
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  // status and path
  input wire logic        i_phase_armed,
  input wire logic        i_phase_busy,
  input wire logic [2:0]  i_out_en,
  input wire logic [2:0]  o_mux_sel,
  input wire logic [2:0]  o_phase_part,
  input wire logic [2:0]  o_pos_pin_oe,
  input wire logic [2:0]  o_neg_pin_oe,
  input wire logic [11:0] o_drive_sect,
  input wire logic [2:0]  o_irq_sum
);
  // ------------------------------
  // write decode
  // ------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic wr_drv;
  logic wr_div;
  logic wr_mux;
  logic wr_st1;
  // strobes for first-output and mux registers
  assign wr_drv = i_reg_wr && i_reg_addr == occs_pkg::ADDR_DRV_CFG_1;
  assign wr_div = i_reg_wr && i_reg_addr == occs_pkg::ADDR_DIV_CFG_1;
  assign wr_mux = i_reg_wr && i_reg_addr == occs_pkg::ADDR_MUX_SEL;
  assign wr_st1 = i_reg_wr && i_reg_addr == occs_pkg::ADDR_STATUS_1;
  // ------------------------------
  // properties
  // ------------------------------
  property p_mux_primary;
    logic [2:0] v;
    (wr_mux && !i_reg_wdata[6], v = i_reg_wdata[2:0]) ##1 (!wr_mux) [*3] |-> o_mux_sel == v;
  endproperty
  mux_primary_a: assert property (p_mux_primary)
    else $error("mux select differs from primary code");
  drive_sections_a: assert property (wr_drv |=>
    o_drive_sect[3:0] == 4'((5'h02 << $past(i_reg_wdata[5:4])) - 5'h01))
    else $error("drive sections wrong for drive code");
  phase_part_a: assert property (wr_div |=> o_phase_part[0] ==
    ($past(i_reg_wdata[7]) && $past(i_reg_wdata[6:0]) != 7'h00))
    else $error("phase participation wrong");
  unmapped_read_a: assert property (i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  phase_read_a: assert property ($stable({i_phase_busy, i_phase_armed}) [*4] ##0
    (i_reg_rd && i_reg_addr == occs_pkg::ADDR_PHASE_STAT) |=>
    o_reg_rdata == {6'h00, $past(i_phase_busy), $past(i_phase_armed)})
    else $error("phase status read wrong");
  out_disable_a: assert property (!i_out_en[0] |-> !o_pos_pin_oe[0] && !o_neg_pin_oe[0])
    else $error("disabled output still driven");
  irq_masked_a: assert property (wr_st1 && (i_reg_wdata & 8'h94) == 8'h00 |=> !o_irq_sum[0])
    else $error("summary set with all enables clear");
  fmt_off_a: assert property (wr_drv && i_reg_wdata[2:0] == 3'h0 |=>
    !o_pos_pin_oe[0] && !o_neg_pin_oe[0])
    else $error("format off still drives");
  fmt_pos_a: assert property (wr_drv && i_reg_wdata[2:0] == 3'h6 && !i_reg_wdata[3] ##1
    i_out_en[0] |-> o_pos_pin_oe[0] && !o_neg_pin_oe[0])
    else $error("positive-only format drive wrong");
  // main scenarios reached
  cover property (wr_st1 ##1 o_irq_sum[0]);
  cover property (i_reg_rd && i_reg_addr == occs_pkg::ADDR_PHASE_STAT && i_phase_busy);
  cover property (!i_out_en[0] && wr_drv);
endmodule

bind occs_top occs_top_assertions chk (
  .i_ref_clk     (i_ref_clk),
  .i_rst_b       (i_rst_b),
  .i_reg_addr    (i_reg_addr),
  .i_reg_wdata   (i_reg_wdata),
  .i_reg_wr      (i_reg_wr),
  .i_reg_rd      (i_reg_rd),
  .o_reg_rdata   (o_reg_rdata),
  .i_phase_armed (i_phase_armed),
  .i_phase_busy  (i_phase_busy),
  .i_out_en      (i_out_en),
  .o_mux_sel     (o_mux_sel),
  .o_phase_part  (o_phase_part),
  .o_pos_pin_oe  (o_pos_pin_oe),
  .o_neg_pin_oe  (o_neg_pin_oe),
  .o_drive_sect  (o_drive_sect),
  .o_irq_sum     (o_irq_sum)
);

// ---- sim/occs_top_bench.sv ----
// testbench: registers, status flags, mux and output path of the control block
`timescale 1ns/1ps
module occs_top_bench;
  // ------------------------------
  // signals and design
  // ------------------------------
  logic        ref_clk, rst_b, reg_wr, reg_rd, path_clk, switch_pin, phase_armed, phase_busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, st, drv, src, div, m;
  logic [2:0]  slow_clk, halted, out_en, mux_sel, phase_part, pos_pin, pos_oe, neg_pin, neg_oe;
  logic [2:0]  irq_sum;
  logic [11:0] drive_sect;
  logic        rd_pend, obs_req, pin;
  logic [7:0]  q_rd[$];
  logic [15:0] q_obs[$];
  logic [1:0]  oe_tab[8] = '{2'b00, 2'b11, 2'b11, 2'b11, 2'b11, 2'b01, 2'b10, 2'b11};
  string       names[7] = '{"mux_sel", "drive_sect", "phase_part", "irq_sum", "pin_oe",
                            "pos_pin", "neg_pin"};
  int          n_mismatch, total_checks;
  int          cycles = 0;
  occs_top dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_path_clk(path_clk), .i_switch_pin(switch_pin), .o_mux_sel(mux_sel),
    .i_phase_armed(phase_armed), .i_phase_busy(phase_busy), .o_phase_part(phase_part),
    .i_slow_clk(slow_clk), .i_halted(halted), .i_out_en(out_en), .o_pos_pin(pos_pin),
    .o_pos_pin_oe(pos_oe), .o_neg_pin(neg_pin), .o_neg_pin_oe(neg_oe),
    .o_drive_sect(drive_sect), .o_irq_sum(irq_sum));
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ------------------------------
  // compare, drive and watch
  // ------------------------------
  task automatic cmp(string nm, logic [11:0] e, logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    q_rd.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(logic [3:0] k, logic [11:0] e);
    q_obs.push_back({k, e});
    @(posedge ref_clk);
    obs_req <= 1'b1;
    @(posedge ref_clk);
    obs_req <= 1'b0;
  endtask
  // watcher: takes the oldest note whenever a result is due
  always @(posedge ref_clk) begin
    logic [15:0] nt;
    logic [11:0] got;
    rd_pend <= reg_rd;
    if (rd_pend) begin
      cmp("rdata", {4'h0, q_rd.pop_front()}, {4'h0, reg_rdata});
    end
    if (obs_req) begin
      nt = q_obs.pop_front();
      case (nt[15:12])
        4'd0: got = {9'h0, mux_sel};
        4'd1: got = drive_sect;
        4'd2: got = {9'h0, phase_part};
        4'd3: got = {9'h0, irq_sum};
        4'd4: got = {10'h0, pos_oe[0], neg_oe[0]};
        4'd5: got = {11'h0, pos_pin[0]};
        default: got = {11'h0, neg_pin[0]};
      endcase
      cmp(names[nt[15:12]], nt[11:0], got);
    end
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, path_clk, switch_pin, phase_armed, phase_busy} = 7'h00;
    {reg_addr, reg_wdata, slow_clk, halted} = 22'h0;
    {out_en, rd_pend, obs_req, n_mismatch, total_checks} = '0;
    out_en = 3'b111;
    st = occs_pkg::ADDR_STATUS_1;
    drv = occs_pkg::ADDR_DRV_CFG_1;
    src = occs_pkg::ADDR_SRC_CFG_1;
    div = occs_pkg::ADDR_DIV_CFG_1;
    void'($urandom(32'h534d));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(3);
    rd(8'h00, 8'h00);
    rd(drv, 8'h00);
    // halt and resume flags on every output
    for (int k = 0; k < 3; k++) begin
      wr(st + 8'(k), 8'h1e);
      rd(st + 8'(k), 8'h14);
      chk(3, 12'h0);
      halted[k] <= 1'b1;
      tick(5);
      rd(st + 8'(k), 8'h17);
      chk(3, 12'(1 << k));
      wr(st + 8'(k), 8'h14);
      rd(st + 8'(k), 8'h17);
      wr(st + 8'(k), 8'h16);
      rd(st + 8'(k), 8'h15);
      halted[k] <= 1'b0;
      tick(5);
      rd(st + 8'(k), 8'h1c);
      wr(st + 8'(k), 8'h00);
      rd(st + 8'(k), 8'h08);
      chk(3, 12'h0);
      wr(st + 8'(k), 8'h08);
      rd(st + 8'(k), 8'h00);
    end
    // slow divider level and edge flag
    wr(src, 8'hc0);
    tick(4);
    rd(st, 8'h20);
    slow_clk[0] <= 1'b1;
    tick(5);
    rd(st, 8'h40);
    wr(st, 8'h80);
    chk(3, 12'h1);
    wr(st, 8'hc0);
    rd(st, 8'h80);
    slow_clk[0] <= 1'b0;
    wr(src, 8'h40);
    slow_clk[0] <= 1'b1;
    tick(5);
    rd(st, 8'h80);
    slow_clk[0] <= 1'b0;
    // phase engine status
    for (int v = 0; v < 4; v++) begin
      phase_armed <= v[0];
      phase_busy <= v[1];
      tick(4);
      rd(occs_pkg::ADDR_PHASE_STAT, 8'(v));
    end
    // input mux: codes 0 to 3 as primary and alternate, then random
    for (int i = 0; i < 12; i++) begin
      if (i < 8) begin
        m = {2'b01, 1'b0, ~i[1:0], 1'b0, i[1:0]};
        pin = i[2];
      end else begin
        m = 8'($urandom) & 8'h5b;
        pin = 1'($urandom);
      end
      switch_pin <= pin;
      path_clk <= 1'($urandom);
      wr(occs_pkg::ADDR_MUX_SEL, m);
      tick(4);
      chk(0, (m[6] && pin) ? {9'h0, m[5:3]} : {9'h0, m[2:0]});
      rd(occs_pkg::ADDR_MUX_SEL, m);
    end
    // drive sections and formats
    for (int d = 0; d < 4; d++) begin
      wr(drv, 8'(d << 4));
      chk(1, 12'h110 | 12'((1 << (d + 1)) - 1));
    end
    for (int f = 0; f < 8; f++) begin
      wr(drv, 8'(f));
      chk(4, {10'h0, oe_tab[f]});
    end
    out_en[0] <= 1'b0;
    tick(2);
    chk(4, 12'h0);
    out_en[0] <= 1'b1;
    // polarity, bypass and source select
    path_clk <= 1'b1;
    wr(drv, 8'h46);
    chk(5, 12'h0);
    wr(drv, 8'h06);
    wr(src, 8'h50);
    chk(5, 12'h1);
    wr(div, 8'h05);
    chk(5, 12'h0);
    slow_clk[0] <= 1'b1;
    chk(5, 12'h1);
    // negative pin from the slow divider, then complementary cmos
    slow_clk[0] <= 1'b0;
    wr(drv, 8'h04);
    wr(src, 8'h60);
    chk(6, 12'h0);
    chk(5, 12'h1);
    wr(drv, 8'h07);
    wr(src, 8'h40);
    chk(6, 12'h0);
    halted[0] <= 1'b1;
    wr(drv, 8'h0e);
    tick(4);
    chk(4, 12'h0);
    wr(div, 8'h00);
    chk(4, 12'h2);
    halted[0] <= 1'b0;
    // phase participation
    wr(div, 8'h85);
    chk(2, 12'h1);
    wr(div + occs_pkg::ADDR_CFG_STRIDE, 8'h81);
    wr(div, 8'h05);
    chk(2, 12'h2);
    tick(4);
    conclude();
  end
endmodule
